// ===== shared/coe_pkg.sv
package coe_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int COE_AW      = 8;
	localparam int COE_DW      = 32;
	localparam int COE_MAX_OUT = 8;
	localparam int COE_DIV_W   = 4;
	localparam int COE_SEL_W   = 2;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] COE_OFS_CTRL    = 8'h00;
	localparam logic [7:0] COE_OFS_PIN0MAP = 8'h04;
	localparam logic [7:0] COE_OFS_PIN1MAP = 8'h08;
	localparam logic [7:0] COE_OFS_REGEN   = 8'h0C;
	localparam logic [7:0] COE_OFS_PARK    = 8'h10;
	localparam logic [7:0] COE_OFS_LOOPSEL = 8'h14;
	localparam logic [7:0] COE_OFS_DIV     = 8'h18;
	localparam logic [7:0] COE_OFS_STATUS  = 8'h1C;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int COE_CTRL_LOL_OFF   = 0;
	localparam int COE_CTRL_XTAL_KEEP = 1;
	localparam int COE_CTRL_SYNC_MODE = 2;
	localparam int COE_CTRL_HARD_RST  = 3;
	localparam int COE_ST_RUN_LSB     = 0;
	localparam int COE_ST_WANT_LSB    = 8;
	localparam int COE_ST_XTAL_BIT    = 16;
	localparam int COE_ST_LOL_LSB     = 20;

	// ----------------------------------------------------------------
	// values after reset
	// ----------------------------------------------------------------
	localparam logic [2:0]  COE_CTRL_RST    = 3'h4;
	localparam logic [7:0]  COE_PIN0MAP_RST = 8'hFF;
	localparam logic [7:0]  COE_PIN1MAP_RST = 8'h00;
	localparam logic [7:0]  COE_REGEN_RST   = 8'hFF;
	localparam logic [7:0]  COE_PARK_RST    = 8'h00;
	localparam logic [15:0] COE_LOOPSEL_RST = 16'h0000;
	localparam logic [31:0] COE_DIV_RST     = 32'h0000_0000;
	localparam logic        COE_SYNC_RST    = 1'b1;

	// ----------------------------------------------------------------
	// output driver states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		COE_ST_OFF   = 3'b001,
		COE_ST_RUN   = 3'b010,
		COE_ST_DRAIN = 3'b100
	} coe_out_st_t;

endpackage

// ===== rtl/coe_out_div.sv
module coe_out_div (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	input  wire logic                          div_rst,
	// configuration
	input  wire logic [coe_pkg::COE_DIV_W-1:0] half_cfg,
	input  wire logic                          sync_mode,
	input  wire logic                          park_lvl,
	input  wire logic                          want_on,
	// results
	output logic                               clk_out,
	output logic                               running
);
	import coe_pkg::*;

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	logic [COE_DIV_W-1:0] cnt_r;
	logic [COE_DIV_W-1:0] cnt_nxt;
	logic                 ph_r;
	logic                 ph_nxt;
	logic                 out_r;
	logic                 out_nxt;
	coe_out_st_t          st_r;
	coe_out_st_t          st_nxt;

	// a shortened half setting ends the running half at once, never a long wrap
	wire tick       = (cnt_r >= half_cfg);
	wire period_end = tick & ph_r;

	// held at zero phase so every output restarts aligned
	assign cnt_nxt = (div_rst | tick) ? '0 : cnt_r + 1'b1;
	assign ph_nxt  = div_rst ? 1'b0 : (tick ? ~ph_r : ph_r);

	// ----------------------------------------------------------------
	// enable state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			COE_ST_OFF: begin
				// in sync mode start only on a period boundary, so no short first pulse
				if (want_on && (!sync_mode || period_end))
					st_nxt = COE_ST_RUN;
			end
			COE_ST_RUN: begin
				if (!want_on) begin
					if (!sync_mode || period_end)
						st_nxt = COE_ST_OFF;
					else
						st_nxt = COE_ST_DRAIN;
				end
			end
			COE_ST_DRAIN: begin
				if (want_on)
					st_nxt = COE_ST_RUN;
				else if (period_end || !sync_mode)
					st_nxt = COE_ST_OFF;
			end
			default: st_nxt = COE_ST_OFF;
		endcase
	end

	assign out_nxt = (st_nxt == COE_ST_OFF) ? park_lvl : ph_nxt;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			ph_r  <= 1'b0;
			st_r  <= COE_ST_OFF;
			out_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ph_r  <= ph_nxt;
			st_r  <= st_nxt;
			out_r <= out_nxt;
		end
	end

	assign clk_out = out_r;
	assign running = (st_r != COE_ST_OFF);

endmodule // coe_out_div

// ===== rtl/coe_top.sv
module coe_top #(
	parameter int NUM_OUT  = 4,
	parameter int NUM_LOOP = 2
) (
	// clock and reset
	input  wire logic                         SYS_CLK,
	input  wire logic                         ARST_N,
	// apb slave
	input  wire logic                         PSEL,
	input  wire logic                         PENABLE,
	input  wire logic                         PWRITE,
	input  wire logic [coe_pkg::COE_AW-1:0]   PADDR,
	input  wire logic [coe_pkg::COE_DW-1:0]   PWDATA,
	output logic      [coe_pkg::COE_DW-1:0]   PRDATA,
	output logic                              PREADY,
	output logic                              PSLVERR,
	// pins from the board
	input  wire logic                         OUTPUT_ENABLE_PIN_0_N,
	input  wire logic                         OUTPUT_ENABLE_PIN_1_N,
	input  wire logic                         RESET_PIN_N,
	// fault alarms from the loops and oscillator
	input  wire logic [NUM_LOOP-1:0]          LOSS_OF_LOCK,
	input  wire logic                         REFERENCE_CRYSTAL_LOSS,
	// power-up image from the nonvolatile store
	input  wire logic                         NONVOLATILE_STORE_VALID,
	input  wire logic [NUM_OUT-1:0]           NONVOLATILE_STORE_MAP0,
	input  wire logic [NUM_OUT-1:0]           NONVOLATILE_STORE_MAP1,
	// clock outputs
	output logic      [NUM_OUT-1:0]           CLOCK_OUTPUT_N
);
	import coe_pkg::*;

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_s1_r;
	logic rst_s2_r;

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end

	wire rst_n = rst_s2_r;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int SW = NUM_LOOP + 4;

	logic [SW-1:0] pin_s1_r;
	logic [SW-1:0] pin_s2_r;

	wire [SW-1:0] pin_raw = {RESET_PIN_N, REFERENCE_CRYSTAL_LOSS,
		OUTPUT_ENABLE_PIN_1_N, OUTPUT_ENABLE_PIN_0_N, LOSS_OF_LOCK};

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= {SW{COE_SYNC_RST}};
			pin_s2_r <= {SW{COE_SYNC_RST}};
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	wire [NUM_LOOP-1:0] lol_s     = pin_s2_r[NUM_LOOP-1:0];
	wire                oe0_n_s   = pin_s2_r[NUM_LOOP];
	wire                oe1_n_s   = pin_s2_r[NUM_LOOP+1];
	wire                xtal_s    = pin_s2_r[NUM_LOOP+2];
	wire                rstpin_n_s = pin_s2_r[NUM_LOOP+3];

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire setup_ph = PSEL & ~PENABLE;
	wire access_ph = PSEL & PENABLE;
	wire wr_en    = access_ph & PWRITE;

	wire hit_ctrl    = (PADDR == COE_OFS_CTRL);
	wire hit_pin0map = (PADDR == COE_OFS_PIN0MAP);
	wire hit_pin1map = (PADDR == COE_OFS_PIN1MAP);
	wire hit_regen   = (PADDR == COE_OFS_REGEN);
	wire hit_park    = (PADDR == COE_OFS_PARK);
	wire hit_loopsel = (PADDR == COE_OFS_LOOPSEL);
	wire hit_div     = (PADDR == COE_OFS_DIV);
	wire hit_status  = (PADDR == COE_OFS_STATUS);

	wire mapped = hit_ctrl | hit_pin0map | hit_pin1map | hit_regen |
		hit_park | hit_loopsel | hit_div | hit_status;

	// zero wait states; unmapped addresses answer with an error
	assign PREADY  = 1'b1;
	assign PSLVERR = access_ph & ~mapped;

	// ----------------------------------------------------------------
	// write strobes
	// ----------------------------------------------------------------
	// status has no strobe: writes there are dropped without error
	wire wr_ctrl    = wr_en & hit_ctrl;
	wire wr_pin0map = wr_en & hit_pin0map;
	wire wr_pin1map = wr_en & hit_pin1map;
	wire wr_regen   = wr_en & hit_regen;
	wire wr_park    = wr_en & hit_park;
	wire wr_loopsel = wr_en & hit_loopsel;
	wire wr_div     = wr_en & hit_div;

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [2:0]                   ctrl_r;
	logic                         hard_rst_r;
	logic [NUM_OUT-1:0]           map0_r;
	logic [NUM_OUT-1:0]           map1_r;
	logic [NUM_OUT-1:0]           regen_r;
	logic [NUM_OUT-1:0]           park_r;
	logic [NUM_OUT*COE_SEL_W-1:0] loopsel_r;
	logic [NUM_OUT*COE_DIV_W-1:0] div_r;
	logic                         nv_done_r;

	// the store image is applied once, on the first cycle after release
	wire nv_load = ~nv_done_r & NONVOLATILE_STORE_VALID;

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			nv_done_r <= 1'b0;
		else
			nv_done_r <= 1'b1;
	end

	// store image outranks a bus write in its single cycle
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			map0_r <= COE_PIN0MAP_RST[NUM_OUT-1:0];
		else if (nv_load)
			map0_r <= NONVOLATILE_STORE_MAP0;
		else if (wr_pin0map)
			map0_r <= PWDATA[NUM_OUT-1:0];
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			map1_r <= COE_PIN1MAP_RST[NUM_OUT-1:0];
		else if (nv_load)
			map1_r <= NONVOLATILE_STORE_MAP1;
		else if (wr_pin1map)
			map1_r <= PWDATA[NUM_OUT-1:0];
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			ctrl_r <= COE_CTRL_RST;
		else if (wr_ctrl)
			ctrl_r <= PWDATA[2:0];
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			regen_r <= COE_REGEN_RST[NUM_OUT-1:0];
		else if (wr_regen)
			regen_r <= PWDATA[NUM_OUT-1:0];
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			park_r <= COE_PARK_RST[NUM_OUT-1:0];
		else if (wr_park)
			park_r <= PWDATA[NUM_OUT-1:0];
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			loopsel_r <= COE_LOOPSEL_RST[NUM_OUT*COE_SEL_W-1:0];
		else if (wr_loopsel)
			loopsel_r <= PWDATA[NUM_OUT*COE_SEL_W-1:0];
	end

	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			div_r <= COE_DIV_RST[NUM_OUT*COE_DIV_W-1:0];
		else if (wr_div)
			div_r <= PWDATA[NUM_OUT*COE_DIV_W-1:0];
	end

	// hard reset bit reads back zero; it lives for one cycle only
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			hard_rst_r <= 1'b0;
		else
			hard_rst_r <= wr_ctrl & PWDATA[COE_CTRL_HARD_RST];
	end

	wire lol_off_en = ctrl_r[COE_CTRL_LOL_OFF];
	wire xtal_keep  = ctrl_r[COE_CTRL_XTAL_KEEP];
	wire sync_mode  = ctrl_r[COE_CTRL_SYNC_MODE];
	wire div_rst    = hard_rst_r | ~rstpin_n_s;

	// ----------------------------------------------------------------
	// per-output gating and drivers
	// ----------------------------------------------------------------
	logic [3:0]         lol_pad;
	logic [NUM_OUT-1:0] want_on;
	logic [NUM_OUT-1:0] running;

	always_comb begin
		lol_pad = '0;
		lol_pad[NUM_LOOP-1:0] = lol_s;
	end

	// crystal alarm blocks every output unless software chose to ride it out
	wire xtal_off = xtal_s & ~xtal_keep;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			wire [COE_SEL_W-1:0] sel = loopsel_r[gi*COE_SEL_W +: COE_SEL_W];

			// low on a pin means run; an unmapped pin never blocks
			wire pin0_ok = ~map0_r[gi] | ~oe0_n_s;
			wire pin1_ok = ~map1_r[gi] | ~oe1_n_s;
			wire lol_off = lol_off_en & lol_pad[sel];

			assign want_on[gi] = pin0_ok & pin1_ok & regen_r[gi] & ~lol_off & ~xtal_off;

			coe_out_div u_div (
				.clk       (SYS_CLK),
				.rst_n     (rst_n),
				.div_rst   (div_rst),
				.half_cfg  (div_r[gi*COE_DIV_W +: COE_DIV_W]),
				.sync_mode (sync_mode),
				.park_lvl  (park_r[gi]),
				.want_on   (want_on[gi]),
				.clk_out   (CLOCK_OUTPUT_N[gi]),
				.running   (running[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [COE_DW-1:0] status_w;
	logic [COE_DW-1:0] rd_mux;
	logic [COE_DW-1:0] prdata_r;

	always_comb begin
		status_w = '0;
		status_w[COE_ST_RUN_LSB +: NUM_OUT]   = running;
		status_w[COE_ST_WANT_LSB +: NUM_OUT]  = want_on;
		status_w[COE_ST_XTAL_BIT]             = xtal_s;
		status_w[COE_ST_LOL_LSB +: NUM_LOOP]  = lol_s;
	end

	always_comb begin
		rd_mux = '0;
		if (hit_ctrl)
			rd_mux[2:0] = ctrl_r;
		if (hit_pin0map)
			rd_mux[NUM_OUT-1:0] = map0_r;
		if (hit_pin1map)
			rd_mux[NUM_OUT-1:0] = map1_r;
		if (hit_regen)
			rd_mux[NUM_OUT-1:0] = regen_r;
		if (hit_park)
			rd_mux[NUM_OUT-1:0] = park_r;
		if (hit_loopsel)
			rd_mux[NUM_OUT*COE_SEL_W-1:0] = loopsel_r;
		if (hit_div)
			rd_mux[NUM_OUT*COE_DIV_W-1:0] = div_r;
		if (hit_status)
			rd_mux = status_w;
	end

	// sampled in the setup cycle so the access phase needs no wait
	always_ff @(posedge SYS_CLK or negedge rst_n) begin
		if (!rst_n)
			prdata_r <= '0;
		else if (setup_ph & ~PWRITE)
			prdata_r <= rd_mux;
	end

	assign PRDATA = prdata_r;

endmodule // coe_top

// ===== tb/coe_props.sv
module coe_props #(
	parameter int NUM_OUT = 4
) (
	// clock, reset
	input wire logic								SYS_CLK,
	input wire logic								ARST_N,
	// apb
	input wire logic								PSEL,
	input wire logic								PENABLE,
	input wire logic								PWRITE,
	input wire logic [coe_pkg::COE_AW-1:0]	PADDR,
	input wire logic [coe_pkg::COE_DW-1:0]	PWDATA,
	input wire logic								PREADY,
	input wire logic								PSLVERR,
	// pins, outputs
	input wire logic								RESET_PIN_N,
	input wire logic								REFERENCE_CRYSTAL_LOSS,
	input wire logic [NUM_OUT-1:0]			CLOCK_OUTPUT_N
);
	timeunit 1ns;
	timeprecision 1ns;
	import coe_pkg::*;
	// ----
	// snooped config and watch counters
	// ----
	logic [2:0]	ctrl_r;
	logic [3:0]	div0_r;
	logic [5:0]	xcnt_r;
	logic [4:0]	hi_r;
	logic		wr_ok;
	assign wr_ok = PSEL && PENABLE && PWRITE && PREADY;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_r <= COE_CTRL_RST;
			div0_r <= 4'h0;
			xcnt_r <= 6'h00;
			hi_r <= 5'h00;
		end else begin
			if (wr_ok && PADDR == COE_OFS_CTRL) ctrl_r <= PWDATA[2:0];
			if (wr_ok && PADDR == COE_OFS_DIV) div0_r <= PWDATA[3:0];
			// saturates so a long alarm stays armed
			xcnt_r <= (REFERENCE_CRYSTAL_LOSS && !ctrl_r[1]) ? xcnt_r + 6'(xcnt_r != 6'h3F) : 6'h00;
			hi_r <= CLOCK_OUTPUT_N[0] ? hi_r + 5'h01 : 5'h00;
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	sequence s_parked;
		$stable(CLOCK_OUTPUT_N) [*4];
	endsequence
	a_ready_high: assert property (PREADY)
		else $error("ready low");
	a_err_phase: assert property (PSLVERR |-> PSEL && PENABLE)
		else $error("error outside access");
	a_err_unmapped: assert property (PSEL && PENABLE && PADDR > COE_OFS_STATUS |-> PSLVERR)
		else $error("unmapped access taken");
	a_reset_quiet: assert property ($rose(ARST_N) |-> CLOCK_OUTPUT_N == '0 ##1 CLOCK_OUTPUT_N == '0)
		else $error("output active in reset");
	a_pinrst_hold: assert property (!RESET_PIN_N [*6] |-> $stable(CLOCK_OUTPUT_N))
		else $error("divider ran in reset");
	a_xtal_park: assert property (xcnt_r >= 6'h28 |-> $stable(CLOCK_OUTPUT_N))
		else $error("output ran on crystal loss");
	a_async_stop: assert property ($rose(REFERENCE_CRYSTAL_LOSS) && ctrl_r[2:1] == 2'b00 |-> ##4 s_parked)
		else $error("late async disable");
	a_sync_whole: assert property ($fell(CLOCK_OUTPUT_N[0]) && ctrl_r[2] |-> hi_r == 5'(div0_r) + 5'h01)
		else $error("runt high half");
endmodule // coe_props

// ===== tb/coe_partner.sv
module coe_partner (
	// bench control
	input wire logic		clk,
	input wire logic		clr,
	input wire logic [1:0]	permit,
	// clock loads
	input wire logic [3:0]	clk_in,
	output logic [1:0]		pin_n,
	output logic [3:0]		seen_r
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]	last_r;
	// enable logic pulls low to let outputs run
	assign pin_n = ~permit;
	// a load only cares whether edges arrived
	always_ff @(posedge clk) begin
		last_r <= clk_in;
		seen_r <= clr ? 4'h0 : seen_r | (clk_in ^ last_r);
	end
endmodule // coe_partner

// ===== tb/test_clock_output_enable_control.sv
module test_clock_output_enable_control;
	timeunit 1ns;
	timeprecision 1ns;
	import coe_pkg::*;
	// ----
	// signals
	// ----
	logic			clk, arst_n, psel, penable, pwrite, pready, pslverr, clr, xtal, rst_pin_n, nv_valid;
	logic [7:0]		paddr;
	logic [31:0]	pwdata, prdata, q;
	logic [1:0]		permit, pin_n, loss_of_lock;
	logic [3:0]		nv_map0, nv_map1, clk_out, seen;
	int				err_total, tests_run;
	coe_top #(.NUM_OUT(4), .NUM_LOOP(2)) u_dut (
		.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.OUTPUT_ENABLE_PIN_0_N(pin_n[0]), .OUTPUT_ENABLE_PIN_1_N(pin_n[1]), .RESET_PIN_N(rst_pin_n),
		.LOSS_OF_LOCK(loss_of_lock), .REFERENCE_CRYSTAL_LOSS(xtal), .NONVOLATILE_STORE_VALID(nv_valid),
		.NONVOLATILE_STORE_MAP0(nv_map0), .NONVOLATILE_STORE_MAP1(nv_map1), .CLOCK_OUTPUT_N(clk_out)
	);
	coe_partner u_load (.clk(clk), .clr(clr), .permit(permit), .clk_in(clk_out), .pin_n(pin_n), .seen_r(seen));
	// ----
	// helpers
	// ----
	task automatic chk(input string s, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("MISMATCH %s exp %h seen %h", s, exp, got);
			err_total++;
		end
	endtask
	task automatic tally_and_finish;
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		{psel, penable} <= 2'b00;
		if (n >= 16) begin
			err_total++;
			tally_and_finish;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(s, q, e);
	endtask
	// settle past sync flops and a full period, then watch for edges
	task automatic obs(input string s, input logic [3:0] e);
		repeat (40) @(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (40) @(posedge clk);
		chk(s, seen, e);
	endtask
	task automatic aligned(input string s);
		repeat (8) begin
			@(posedge clk);
			chk(s, 32'(clk_out === 4'h0 || clk_out === 4'hF), 32'h1);
		end
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_defaults;
		rdc("ctrl", COE_OFS_CTRL, 32'h4);
		rdc("pin1 map", COE_OFS_PIN1MAP, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		permit <= 2'b01;
		obs("pin1 idle", 4'hF);
		rdc("status", COE_OFS_STATUS, 32'h0F0F);
		permit <= 2'b10;
		obs("pin0 off", 4'h0);
		chk("park low", clk_out, 4'h0);
	endtask
	task automatic t_map;
		wr(COE_OFS_PIN0MAP, 32'h3);
		wr(COE_OFS_PIN1MAP, 32'hC);
		permit <= 2'b01;
		obs("pin0 map", 4'h3);
		permit <= 2'b10;
		obs("pin1 map", 4'hC);
		permit <= 2'b11;
		wr(COE_OFS_REGEN, 32'hA);
		obs("reg off", 4'hA);
		wr(COE_OFS_REGEN, 32'hFF);
		wr(COE_OFS_PIN0MAP, 32'hFF);
		wr(COE_OFS_PIN1MAP, 32'h0);
	endtask
	task automatic t_lol;
		wr(COE_OFS_LOOPSEL, 32'h50);
		loss_of_lock <= 2'b10;
		obs("lol run", 4'hF);
		wr(COE_OFS_CTRL, 32'h5);
		obs("lol off", 4'h3);
		loss_of_lock <= 2'b01;
		obs("lol loop0", 4'hC);
		loss_of_lock <= 2'b00;
		wr(COE_OFS_CTRL, 32'h4);
	endtask
	task automatic t_xtal;
		wr(COE_OFS_CTRL, 32'h0);
		wr(COE_OFS_PARK, 32'h5);
		xtal <= 1'b1;
		obs("xtal off", 4'h0);
		chk("park high", clk_out, 4'h5);
		wr(COE_OFS_CTRL, 32'h2);
		obs("xtal keep", 4'hF);
		xtal <= 1'b0;
		wr(COE_OFS_PARK, 32'h0);
		wr(COE_OFS_CTRL, 32'h4);
	endtask
	task automatic t_sync;
		logic [31:0] n;
		permit <= 2'b10;
		repeat (8) @(posedge clk);
		wr(COE_OFS_DIV, 32'h2);
		permit <= 2'b11;
		repeat (20) @(posedge clk);
		n = 0;
		repeat (12) begin
			@(posedge clk);
			n = n + clk_out[0];
		end
		chk("high cycles", n, 32'h6);
		permit <= 2'b10;
		obs("sync off", 4'h0);
		permit <= 2'b11;
	endtask
	// async mode so re-enable lands off the common phase
	task automatic t_divrst;
		wr(COE_OFS_CTRL, 32'h0);
		wr(COE_OFS_DIV, 32'h1111);
		wr(COE_OFS_REGEN, 32'hFD);
		wr(COE_OFS_REGEN, 32'hFF);
		wr(COE_OFS_CTRL, 32'h8);
		repeat (4) @(posedge clk);
		aligned("hard reset");
		wr(COE_OFS_REGEN, 32'hFD);
		wr(COE_OFS_REGEN, 32'hFF);
		rst_pin_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_pin_n <= 1'b1;
		repeat (4) @(posedge clk);
		aligned("reset pin");
		wr(COE_OFS_DIV, 32'h0);
		wr(COE_OFS_CTRL, 32'h4);
	endtask
	task automatic t_nvstore;
		nv_valid <= 1'b1;
		nv_map0 <= 4'h3;
		nv_map1 <= 4'hC;
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		permit <= 2'b10;
		repeat (3) @(posedge clk);
		rdc("stored map", COE_OFS_PIN0MAP, 32'h3);
		rdc("stored map1", COE_OFS_PIN1MAP, 32'hC);
		obs("stored pins", 4'hC);
		nv_valid <= 1'b0;
	endtask
	// ----
	// main
	// ----
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		{arst_n, psel, penable, pwrite, xtal, nv_valid} = '0;
		{clr, rst_pin_n} = 2'b11;
		{paddr, pwdata, permit, loss_of_lock, nv_map0, nv_map1} = '0;
		err_total = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_defaults;
		t_map;
		t_lol;
		t_xtal;
		t_sync;
		t_divrst;
		t_nvstore;
		tally_and_finish;
	end
endmodule // test_clock_output_enable_control

bind coe_top coe_props #(.NUM_OUT(NUM_OUT)) u_props (
	.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .RESET_PIN_N(RESET_PIN_N),
	.REFERENCE_CRYSTAL_LOSS(REFERENCE_CRYSTAL_LOSS), .CLOCK_OUTPUT_N(CLOCK_OUTPUT_N)
);
